// ---- fifo_jtag_tap.sv ----
// fifo_jtag_tap: test access port controller, instruction, id and bypass paths
// assumes pins are asynchronous to clk_sys and the test clock is much slower
`timescale 1ns/1ps
module fifo_jtag_tap
    import tap_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = ID_VALUE_DEFAULT // arbitrary value
) (
    input  wire logic      clk_sys,
    input  wire logic      nrst,
    input  wire tap_pins_t pins,
    input  wire logic      tdiConn,
    input  wire logic      tmsConn,
    input  wire logic      fifoOutEnable,
    output tap_out_t       serOut,
    output logic           tapWasReset,
    output logic           fifoQOe
);
    // floating pins read high as with a pull-up
    logic tdiPin;
    logic tmsPin;
    assign tdiPin = tdiConn ? pins.tdi : 1'b1;
    assign tmsPin = tmsConn ? pins.tms : 1'b1;

    // two-stage synchronisers; first stage feeds only the second
    // reset to the idle pin levels (tck low, tms/tdi pulled high, test
    // reset released) so a system reset never looks like a test reset
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 4'h7;
            sync2_reg <= 4'h7;
        end else begin
            sync1_reg <= {pins.tck, tmsPin, tdiPin, pins.trstN};
            sync2_reg <= sync1_reg;
        end
    end

    logic tckS;
    logic tmsS;
    logic tdiS;
    logic trstNS;
    assign tckS   = sync2_reg[3];
    assign tmsS   = sync2_reg[2];
    assign tdiS   = sync2_reg[1];
    assign trstNS = sync2_reg[0];

    // test clock edge finder
    logic tckLast_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tckLast_reg <= 1'b0;
        end else begin
            tckLast_reg <= tckS;
        end
    end

    logic tckRise;
    logic tckFall;
    assign tckRise = tckS & ~tckLast_reg;
    assign tckFall = ~tckS & tckLast_reg;

    // held test reset: the only path not gated by the test clock
    logic tapClear;
    assign tapClear = ~trstNS;

    // standard controller next-state function
    function automatic tap_state_t tapNext(input tap_state_t s, input logic m);
        unique case (s)
            ST_RESET:    tapNext = m ? ST_RESET    : ST_IDLE;
            ST_IDLE:     tapNext = m ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   tapNext = m ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   tapNext = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: tapNext = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: tapNext = m ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: tapNext = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: tapNext = m ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   tapNext = m ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   tapNext = m ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   tapNext = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: tapNext = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: tapNext = m ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: tapNext = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: tapNext = m ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   tapNext = m ? ST_SEL_DR   : ST_IDLE;
        endcase
    endfunction : tapNext

    // controller state; system reset puts it in idle so that power-up
    // does not count as a proper test reset
    tap_state_t state_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else if (tapClear) begin
            state_reg <= ST_RESET;
        end else if (tckRise) begin
            state_reg <= tapNext(state_reg, tmsS);
        end
    end

    // latched once the controller has reached test-logic-reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tapWasReset <= 1'b0;
        end else if (state_reg == ST_RESET) begin
            tapWasReset <= 1'b1;
        end
    end

    // fifo data drivers stay off until the port was reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fifoQOe <= 1'b0;
        end else begin
            fifoQOe <= tapWasReset & fifoOutEnable;
        end
    end

    // instruction register: shift stage and active copy
    logic [IR_WIDTH-1:0] irShift_reg;
    logic [IR_WIDTH-1:0] ir_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irShift_reg <= IR_CAPTURE;
        end else if (tckRise) begin
            if (state_reg == ST_CAP_IR) begin
                irShift_reg <= IR_CAPTURE;
            end else if (state_reg == ST_SHIFT_IR) begin
                irShift_reg <= {tdiS, irShift_reg[IR_WIDTH-1:1]};
            end
        end
    end

    // active instruction updates on falling edge of update state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ir_reg <= INSTR_IDCODE;
        end else if (tapClear || (state_reg == ST_RESET)) begin
            ir_reg <= INSTR_IDCODE;
        end else if (tckFall && state_reg == ST_UPD_IR) begin
            ir_reg <= irShift_reg;
        end
    end

    logic selId;
    assign selId = (ir_reg == INSTR_IDCODE);

    // id and bypass data registers; other codes fall back to bypass
    logic [ID_WIDTH-1:0] idShift_reg;
    logic                bypass_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            idShift_reg <= 32'h0;
            bypass_reg  <= 1'b0;
        end else if (tckRise) begin
            if (state_reg == ST_CAP_DR) begin
                idShift_reg <= ID_VALUE;
                bypass_reg  <= 1'b0;
            end else if (state_reg == ST_SHIFT_DR) begin
                if (selId) begin
                    idShift_reg <= {tdiS, idShift_reg[ID_WIDTH-1:1]};
                end else begin
                    bypass_reg <= tdiS;
                end
            end
        end
    end

    // serial output and its enable change on the falling edge or clear on test reset,
    // so the host samples a stable value on the next rise
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            serOut <= '0;
        end else if (tapClear) begin
            serOut <= '0;
        end else if (tckFall) begin
            unique case (state_reg)
                ST_SHIFT_IR: begin
                    serOut.tdo   <= irShift_reg[0];
                    serOut.tdoOe <= 1'b1;
                end
                ST_SHIFT_DR: begin
                    serOut.tdo   <= selId ? idShift_reg[0] : bypass_reg;
                    serOut.tdoOe <= 1'b1;
                end
                default: begin
                    serOut.tdo   <= 1'b0;
                    serOut.tdoOe <= 1'b0;
                end
            endcase
        end
    end
endmodule : fifo_jtag_tap

// ---- fifo_jtag_tap_assertions.sv ----
// checker on the test port pins and the fifo output gate
// assumes the bench keeps tck low while test reset is low
`timescale 1ns/1ps
module fifo_jtag_tap_chk
    import tap_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      nrst,
    input wire tap_pins_t pins,
    input wire logic      tdiConn,
    input wire logic      tmsConn,
    input wire logic      fifoOutEnable,
    input wire tap_out_t  serOut,
    input wire logic      tapWasReset,
    input wire logic      fifoQOe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    a_out_on_fall: assert property ($changed(serOut) |-> !pins.tck)
        else $error("tdo moved while tck high");
    a_hold_high: assert property (pins.tck [*5] |=> $stable(serOut))
        else $error("tdo moved late in tck high");
    a_q_blocked: assert property (!tapWasReset |=> !fifoQOe)
        else $error("fifo outputs driven before tap reset");
    a_q_cause: assert property (fifoQOe |-> $past(fifoOutEnable))
        else $error("fifo outputs driven without request");
    a_trst_sets: assert property ($fell(pins.trstN) |-> ##[1:6] tapWasReset)
        else $error("test reset not seen");
    a_trst_quiet: assert property (!pins.trstN [*5] |-> !serOut.tdoOe)
        else $error("tdo driven in test reset");
    a_flag_sticky: assert property (tapWasReset |=> tapWasReset)
        else $error("reset flag dropped");
    a_no_selfreset: assert property ($rose(nrst) |-> !tapWasReset && !fifoQOe)
        else $error("system reset marked tap reset");
    c_oe: cover property ($rose(serOut.tdoOe));
    c_q: cover property ($rose(fifoQOe));
    c_trst: cover property ($fell(pins.trstN));
endmodule : fifo_jtag_tap_chk

bind fifo_jtag_tap fifo_jtag_tap_chk fifo_jtag_tap_chk_i (.clk_sys, .nrst, .pins, .tdiConn, .tmsConn,
    .fifoOutEnable, .serOut, .tapWasReset, .fifoQOe);

// ---- fifo_jtag_tap_tb.sv ----
// bench: host model moves the pins, a queue judges tdo per tck period
// assumes one host result per tck period, in order
`timescale 1ns/1ps
module fifo_jtag_tap_tb;
    import tap_pkg::*;
    localparam logic [31:0] ID = 32'h5ac3_0e81; // arbitrary, low bit set
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    logic       trstN = 1'b1;
    logic       tdiConn = 1'b1;
    logic       tmsConn = 1'b1;
    logic       qEn = 1'b1;
    logic       go = 1'b0;
    logic       tmsB = 1'b0;
    logic       tdiB = 1'b0;
    logic       tck, tms, tdi, done, wasRst, qOe;
    logic [1:0] res;
    logic [2:0] e;
    logic [2:0] expQ[$];
    logic [31:0] r;
    tap_out_t   serOut;
    int         n_mismatch = 0;
    int         n_tests = 0;
    initial forever #2.5 clk_sys = ~clk_sys;
    fifo_jtag_tap #(.ID_VALUE(ID)) fifo_jtag_tap_i (.clk_sys(clk_sys), .nrst(nrst),
        .pins({tck, tms, tdi, trstN}), .tdiConn(tdiConn), .tmsConn(tmsConn), .fifoOutEnable(qEn),
        .serOut(serOut), .tapWasReset(wasRst), .fifoQOe(qOe));
    tap_host tap_host_i (.clk_sys(clk_sys), .go(go), .tmsBit(tmsB), .tdiBit(tdiB), .tdoIn(serOut),
        .tck(tck), .tms(tms), .tdi(tdi), .done(done), .res(res));
    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic a, input logic b);
        n_tests++;
        if (a !== b) begin
            n_mismatch++;
            $display("mismatch %0t flag %b exp %b", $time, a, b);
        end
    endtask : chk
    // e is {judge tdo, expected oe, expected tdo}
    task automatic clk1(input logic m, input logic d, input logic [2:0] x);
        int n;
        expQ.push_back(x);
        @(posedge clk_sys);
        go <= 1'b1;
        tmsB <= m;
        tdiB <= d;
        @(posedge clk_sys);
        go <= 1'b0;
        n = 0;
        while (!done && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        if (!done) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : clk1
    // idle to idle scan of n bits, ir or dr
    task automatic scan(input logic ir, input int n, input logic [31:0] d, input logic [31:0] q);
        clk1(1'b1, 1'b0, 3'h0);
        if (ir) begin
            clk1(1'b1, 1'b0, 3'h0);
        end
        clk1(1'b0, 1'b0, 3'h0);
        clk1(1'b0, 1'b0, 3'h0);
        for (int i = 0; i < n; i++) begin
            clk1(i == n - 1, d[i], {2'h3, q[i]});
        end
        clk1(1'b1, 1'b0, 3'h0);
        clk1(1'b0, 1'b0, 3'h0);
    endtask : scan
    // one note per tck period; tdo judged only where noted
    always @(posedge clk_sys) begin
        if (done) begin
            e = expQ.pop_front();
            n_tests++;
            if (res[1] !== e[1] || (e[2] && res[0] !== e[0])) begin
                n_mismatch++;
                $display("mismatch %0t tdo %b exp %b", $time, res, e[1:0]);
            end
        end
    end
    initial begin
        void'($urandom(22014));
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(qOe, 1'b0);
        repeat (5) clk1(1'b1, 1'b0, 3'h0);
        clk1(1'b0, 1'b0, 3'h0);
        chk(wasRst, 1'b1);
        chk(qOe, 1'b1);
        r = $urandom;
        scan(1'b0, 32, r, ID);
        scan(1'b1, 4, {28'h0, INSTR_BYPASS}, {28'h0, IR_CAPTURE});
        scan(1'b0, 32, r, {r[30:0], 1'b0});
        tdiConn <= 1'b0;
        scan(1'b0, 8, r, 32'hfe);
        tdiConn <= 1'b1;
        tmsConn <= 1'b0;
        repeat (5) clk1(1'b0, 1'b0, 3'h0);
        tmsConn <= 1'b1;
        clk1(1'b0, 1'b0, 3'h0);
        scan(1'b0, 32, 32'h0, ID);
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(qOe, 1'b0);
        trstN <= 1'b0;
        repeat (6) @(posedge clk_sys);
        trstN <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(qOe, 1'b1);
        qEn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(qOe, 1'b0);
        end_of_test();
    end
endmodule : fifo_jtag_tap_tb

// ---- tap_host_model.sv ----
// host model: one tck period per go, tck rests low between bits
// assumes clk_sys at 5 ns, so a period is about 80 ns
`timescale 1ns/1ps
module tap_host
    import tap_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     go,
    input  wire logic     tmsBit,
    input  wire logic     tdiBit,
    input  wire tap_out_t tdoIn,
    output logic          tck = 1'b0,
    output logic          tms = 1'b1,
    output logic          tdi = 1'b1,
    output logic          done = 1'b0,
    output logic [1:0]    res = 2'h0
);
    logic [4:0] cnt = 5'h00;
    // tms/tdi set well before the rise; tdo read just before the rise
    always @(posedge clk_sys) begin
        done <= 1'b0;
        cnt <= (cnt == 5'h00) ? {4'h0, go} : cnt + 5'h01;
        if (go && cnt == 5'h00) begin
            tms <= tmsBit;
            tdi <= tdiBit;
        end
        if (cnt == 5'h03) begin
            res <= {tdoIn.tdoOe, tdoIn.tdo};
            tck <= 1'b1;
        end
        if (cnt == 5'h0b) begin
            tck <= 1'b0;
        end
        if (cnt == 5'h10) begin
            done <= 1'b1;
            cnt <= 5'h00;
        end
    end
endmodule : tap_host

// ---- tap_pkg.sv ----
// tap_pkg: constants, states and carrier types for the FIFO test access port
// assumes a single system clock that oversamples the test clock pin
// Summary of operation
// - four test pins plus optional async reset
// - sample mode and data on rising test clock
// - outputs change only on falling test clock or test reset; fifoQOe and tapWasReset follow clk_sys
// - shift data into selected register on rise
// - drive serial output on falling edge
// - serial output driven only in shift states
// - floating data input reads as high
// - mode input steers states, floating reads high
// - test reset clears controller asynchronously
// - no power-up reset; host resets controller
// - fifo outputs tristate until controller reset
package tap_pkg;
    localparam int IR_WIDTH = 4;
    localparam int ID_WIDTH = 32;
    localparam int Q_WIDTH  = 36;
    // instruction codes
    localparam logic [3:0] INSTR_EXTEST   = 4'h0;
    localparam logic [3:0] INSTR_IDCODE   = 4'h2;
    localparam logic [3:0] INSTR_BYPASS   = 4'hf;
    // captured into the instruction register, low two bits per convention
    localparam logic [3:0] IR_CAPTURE     = 4'h1;
    // identification value; arbitrary, low bit must be one
    localparam logic [31:0] ID_VALUE_DEFAULT = 32'h0000_0001;

    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h2,
        ST_CAP_DR   = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR   = 4'h8,
        ST_SEL_IR   = 4'h9,
        ST_CAP_IR   = 4'ha,
        ST_SHIFT_IR = 4'hb,
        ST_EXIT1_IR = 4'hc,
        ST_PAUSE_IR = 4'hd,
        ST_EXIT2_IR = 4'he,
        ST_UPD_IR   = 4'hf
    } tap_state_t;

    // test pins as seen by the device
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trstN;
    } tap_pins_t;

    // serial output pin as data and enable
    typedef struct packed {
        logic tdo;
        logic tdoOe;
    } tap_out_t;
endpackage : tap_pkg
